// ### pkg/vecirq_pkg.sv
/*
  shared constants and carrier types for the interrupt enable/select front end.
  assumes a 32-bit apb slave port and 32 request sources.
*/
package vecirq_pkg;

  localparam int unsigned VECIRQ_SRC_W = 32;
  localparam int unsigned VECIRQ_SYNC_STAGES = 3;

  // register byte addresses
  localparam logic [31:0] VECIRQ_RAW_STATUS_ADDR = 32'hFFFFF008;
  localparam logic [31:0] VECIRQ_CLASS_SEL_ADDR = 32'hFFFFF00C;
  localparam logic [31:0] VECIRQ_EN_SET_ADDR = 32'hFFFFF010;
  localparam logic [31:0] VECIRQ_EN_CLR_ADDR = 32'hFFFFF014;

  // reset values, and read data for the write-only and unmapped addresses
  localparam logic [31:0] VECIRQ_RAW_STATUS_RST = 32'h00000000;
  localparam logic [31:0] VECIRQ_CLASS_SEL_RST = 32'h00000000;
  localparam logic [31:0] VECIRQ_EN_SET_RST = 32'h00000000;
  localparam logic [31:0] VECIRQ_RDATA_NONE = 32'h00000000;

  // classification bit values
  localparam logic VECIRQ_CLASS_NORMAL = 1'h0;
  localparam logic VECIRQ_CLASS_FAST = 1'h1;

  // fixed source bit positions
  localparam int unsigned VECIRQ_POS_WATCHDOG = 0;
  localparam int unsigned VECIRQ_POS_CORE_DEBUG_A = 2;
  localparam int unsigned VECIRQ_POS_CORE_DEBUG_B = 3;
  localparam int unsigned VECIRQ_POS_COUNTER_A = 4;
  localparam int unsigned VECIRQ_POS_COUNTER_B = 5;
  localparam int unsigned VECIRQ_POS_SERIAL_PORT_A = 6;
  localparam int unsigned VECIRQ_POS_SERIAL_PORT_B = 7;
  localparam int unsigned VECIRQ_POS_TWO_WIRE_A = 9;
  localparam int unsigned VECIRQ_POS_SYNC_SERIAL_A = 10;
  localparam int unsigned VECIRQ_POS_SYNC_SERIAL_B = 11;
  localparam int unsigned VECIRQ_POS_CLOCK_SYNTH = 12;
  localparam int unsigned VECIRQ_POS_CLOCK_CAL = 13;
  localparam int unsigned VECIRQ_POS_EXT_PIN_A = 14;
  localparam int unsigned VECIRQ_POS_EXT_PIN_B = 15;
  localparam int unsigned VECIRQ_POS_EXT_PIN_C = 16;
  localparam int unsigned VECIRQ_POS_CONVERTER = 18;
  localparam int unsigned VECIRQ_POS_TWO_WIRE_B = 19;
  localparam int unsigned VECIRQ_POS_COUNTER_C = 26;
  localparam int unsigned VECIRQ_POS_COUNTER_D = 27;

  typedef enum logic [2:0] {
    VECIRQ_SEL_NONE,
    VECIRQ_SEL_RAW,
    VECIRQ_SEL_CLASS,
    VECIRQ_SEL_EN_SET,
    VECIRQ_SEL_EN_CLR
  } vecirq_sel_t;

  typedef struct packed {
    logic [31:0] addr;
    logic write;
    logic [31:0] wdata;
    logic [3:0] strb;
  } vecirq_apb_req_t;

  typedef struct packed {
    logic [31:0] fast;
    logic [31:0] normal;
  } vecirq_route_t;

endpackage : vecirq_pkg

// ### rtl/vecirq_pin_sync.sv
/*
  three-stage synchroniser for the peripheral request lines.
  assumes the lines may change at any time relative to mclk.
*/
`timescale 1ns/1ps
module vecirq_pin_sync
  import vecirq_pkg::*;
#(
  parameter int unsigned WIDTH = VECIRQ_SRC_W
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] stable;
  } vecirq_sync_state_t;

  vecirq_sync_state_t state_r;
  vecirq_sync_state_t state_nxt;

  if (WIDTH < 1) begin : g_width_check
    $error("vecirq_pin_sync: width must be at least 1");
  end

  always_comb begin
    state_nxt = state_r;
    state_nxt.s1 = async_in;
    state_nxt.s2 = state_r.s1;
    state_nxt.s3 = state_r.s2;
    // a change counts once stages two and three agree
    for (int i = 0; i < WIDTH; i++) begin
      if (state_r.s2[i] == state_r.s3[i]) begin
        state_nxt.stable[i] = state_r.s3[i];
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_r <= '0;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  assign sync_out = state_r.stable;

endmodule : vecirq_pin_sync

// ### rtl/vecirq_route.sv
/*
  enable gating and fast/normal classification of raw source bits.
  assumes raw, enable and class vectors come from flip-flops on mclk.
*/
`timescale 1ns/1ps
module vecirq_route
  import vecirq_pkg::*;
#(
  parameter int unsigned WIDTH = VECIRQ_SRC_W
) (
  input wire logic [WIDTH-1:0] raw,
  input wire logic [WIDTH-1:0] enable,
  input wire logic [WIDTH-1:0] class_sel,
  output vecirq_route_t routed
);

  logic [WIDTH-1:0] gated;

  assign gated = raw & enable;

  always_comb begin
    routed = '0;
    for (int i = 0; i < WIDTH; i++) begin
      if (class_sel[i] == VECIRQ_CLASS_FAST) begin
        routed.fast[i] = gated[i];
      end else begin
        routed.normal[i] = gated[i];
      end
    end
  end

endmodule : vecirq_route

// ### rtl/vecirq_top.sv
/*
  interrupt enable/select front end: raw status, enable mask set/clear,
  fast/normal classification, apb register slave.
  assumes an apb master on mclk, request lines from other domains,
  force bits from logic on mclk.
*/
// Design decision made here: register access over APB.
`timescale 1ns/1ps
module vecirq_top
  import vecirq_pkg::*;
#(
  parameter int unsigned NUM_SRC = VECIRQ_SRC_W
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [NUM_SRC-1:0] periph_req,
  input wire logic [NUM_SRC-1:0] software_force_bits,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [NUM_SRC-1:0] fast_req_vec,
  output logic [NUM_SRC-1:0] normal_req_vec,
  output logic fast_interrupt_out,
  output logic normal_interrupt_out
);

  typedef struct packed {
    logic [NUM_SRC-1:0] raw;
    logic [NUM_SRC-1:0] enable;
    logic [NUM_SRC-1:0] class_sel;
    logic [NUM_SRC-1:0] fast_vec;
    logic [NUM_SRC-1:0] normal_vec;
    logic fast_out;
    logic normal_out;
    logic [31:0] rdata;
    logic slverr;
    logic captured;
  } vecirq_state_t;

  vecirq_state_t state_r;
  vecirq_state_t state_nxt;
  vecirq_apb_req_t req;
  vecirq_route_t routed;
  logic [NUM_SRC-1:0] req_sync;
  logic [31:0] wmask;
  logic [31:0] lanes;
  vecirq_sel_t sel;
  logic setup_ph;
  logic access_ph;

  if (NUM_SRC < 1 || NUM_SRC > 32) begin : g_num_src_check
    $error("vecirq_top: NUM_SRC must be 1 to 32");
  end

  function automatic vecirq_sel_t decode(input logic [31:0] addr);
    unique case (addr)
      VECIRQ_RAW_STATUS_ADDR: decode = VECIRQ_SEL_RAW;
      VECIRQ_CLASS_SEL_ADDR: decode = VECIRQ_SEL_CLASS;
      VECIRQ_EN_SET_ADDR: decode = VECIRQ_SEL_EN_SET;
      VECIRQ_EN_CLR_ADDR: decode = VECIRQ_SEL_EN_CLR;
      default: decode = VECIRQ_SEL_NONE;
    endcase
  endfunction : decode

  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction : strb_mask

  function automatic logic [31:0] widen(input logic [NUM_SRC-1:0] v);
    widen = 32'h00000000;
    widen[NUM_SRC-1:0] = v;
  endfunction : widen

  vecirq_pin_sync #(
    .WIDTH(NUM_SRC)
  ) u_sync (
    .mclk(mclk),
    .rstn(rstn),
    .ce(ce),
    .async_in(periph_req),
    .sync_out(req_sync)
  );

  vecirq_route #(
    .WIDTH(NUM_SRC)
  ) u_route (
    .raw(state_r.raw),
    .enable(state_r.enable),
    .class_sel(state_r.class_sel),
    .routed(routed)
  );

  assign req.addr = paddr;
  assign req.write = pwrite;
  assign req.wdata = pwdata;
  assign req.strb = pstrb;
  assign sel = decode(req.addr);
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign lanes = strb_mask(req.strb);
  assign wmask = req.wdata & lanes;

  always_comb begin
    state_nxt = state_r;
    // source positions are fixed by wiring of periph_req
    state_nxt.raw = req_sync | software_force_bits;
    state_nxt.fast_vec = routed.fast[NUM_SRC-1:0];
    state_nxt.normal_vec = routed.normal[NUM_SRC-1:0];
    state_nxt.fast_out = |routed.fast;
    state_nxt.normal_out = |routed.normal;
    // read data captured in setup; a setup edge lost to ce low costs one wait state
    if (setup_ph || (access_ph && !state_r.captured)) begin
      state_nxt.captured = 1'h1;
      state_nxt.slverr = (sel == VECIRQ_SEL_NONE);
      unique case (sel)
        VECIRQ_SEL_RAW: state_nxt.rdata = widen(state_r.raw);
        VECIRQ_SEL_CLASS: state_nxt.rdata = widen(state_r.class_sel);
        VECIRQ_SEL_EN_SET: state_nxt.rdata = widen(state_r.enable);
        VECIRQ_SEL_EN_CLR: state_nxt.rdata = VECIRQ_RDATA_NONE;
        VECIRQ_SEL_NONE: state_nxt.rdata = VECIRQ_RDATA_NONE;
      endcase
    end
    if (access_ph && state_r.captured) begin
      state_nxt.captured = 1'h0;
      if (req.write) begin
        unique case (sel)
          VECIRQ_SEL_CLASS: begin
            state_nxt.class_sel = (state_r.class_sel & ~lanes[NUM_SRC-1:0])
              | (req.wdata[NUM_SRC-1:0] & lanes[NUM_SRC-1:0]);
          end
          VECIRQ_SEL_EN_SET: begin
            state_nxt.enable = state_r.enable | wmask[NUM_SRC-1:0];
          end
          VECIRQ_SEL_EN_CLR: begin
            state_nxt.enable = state_r.enable & ~wmask[NUM_SRC-1:0];
          end
          VECIRQ_SEL_RAW: begin
            state_nxt.raw = req_sync | software_force_bits;
          end
          VECIRQ_SEL_NONE: begin
            state_nxt.slverr = 1'h1;
          end
        endcase
      end
    end
    if (!psel) begin
      state_nxt.captured = 1'h0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_r <= '0;
      state_r.raw <= VECIRQ_RAW_STATUS_RST[NUM_SRC-1:0];
      state_r.enable <= VECIRQ_EN_SET_RST[NUM_SRC-1:0];
      state_r.class_sel <= VECIRQ_CLASS_SEL_RST[NUM_SRC-1:0];
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  assign pready = access_ph && ce && state_r.captured;
  assign prdata = state_r.rdata;
  assign pslverr = access_ph && state_r.captured && state_r.slverr;
  assign fast_req_vec = state_r.fast_vec;
  assign normal_req_vec = state_r.normal_vec;
  assign fast_interrupt_out = state_r.fast_out;
  assign normal_interrupt_out = state_r.normal_out;

endmodule : vecirq_top

// ### verification/vecirq_chk.sv
/* port-level checker for vecirq_top.
   assumes the bind below and one clock domain on mclk. */
`timescale 1ns/1ps
module vecirq_chk
  import vecirq_pkg::*;
#(
  parameter int unsigned NUM_SRC = VECIRQ_SRC_W
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [NUM_SRC-1:0] periph_req,
  input wire logic [NUM_SRC-1:0] software_force_bits,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NUM_SRC-1:0] fast_req_vec,
  input wire logic [NUM_SRC-1:0] normal_req_vec,
  input wire logic fast_interrupt_out,
  input wire logic normal_interrupt_out
);
  logic [3:0] quiet_r;
  logic rd_acc;
  logic [NUM_SRC-1:0] raw;
  assign rd_acc = psel && penable && pready && !pwrite;
  assign raw = periph_req | software_force_bits;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // edges since sources last moved, ce high
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      quiet_r <= 4'h0;
    end else if (!ce || !$stable(raw)) begin
      quiet_r <= 4'h0;
    end else if (quiet_r != 4'h8) begin
      quiet_r <= quiet_r + 4'h1;
    end
  end
  raw_view_a: assert property (rd_acc && paddr == VECIRQ_RAW_STATUS_ADDR && quiet_r > 4'h6 |-> prdata == 32'(raw))
    else $error("raw read differs from sources");
  raw_gate_a: assert property (quiet_r > 4'h6 |-> ((fast_req_vec | normal_req_vec) & ~raw) == '0)
    else $error("routed bit without raw source");
  class_excl_a: assert property ((fast_req_vec & normal_req_vec) == '0)
    else $error("source routed to both outputs");
  fast_out_a: assert property ((fast_req_vec == '0) [*3] |-> !fast_interrupt_out)
    else $error("fast output without source");
  normal_out_a: assert property ((normal_req_vec == '0) [*3] |-> !normal_interrupt_out)
    else $error("normal output without source");
  en_clr_rd_a: assert property (rd_acc && paddr == VECIRQ_EN_CLR_ADDR |-> prdata == 32'h0 && !pslverr)
    else $error("enable clear read not zero");
  raw_wr_a: assert property (psel && penable && pwrite && paddr == VECIRQ_RAW_STATUS_ADDR |-> !pslverr)
    else $error("raw status write refused");
  reset_zero_a: assert property ($rose(rstn) |-> (fast_req_vec | normal_req_vec) == '0 && !fast_interrupt_out)
    else $error("outputs not clear after reset");
endmodule : vecirq_chk

bind vecirq_top vecirq_chk #(
  .NUM_SRC(NUM_SRC)
) u_vecirq_chk (
  .mclk(mclk),
  .rstn(rstn),
  .ce(ce),
  .periph_req(periph_req),
  .software_force_bits(software_force_bits),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .fast_req_vec(fast_req_vec),
  .normal_req_vec(normal_req_vec),
  .fast_interrupt_out(fast_interrupt_out),
  .normal_interrupt_out(normal_interrupt_out)
);

// ### verification/vecirq_src_model.sv
/* partner: peripheral request sources.
   assumes the bench sets req_cmd; slow adds a cycle of lag. */
`timescale 1ns/1ps
module vecirq_src_model (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic slow,
  input wire logic [31:0] req_cmd,
  output logic [31:0] periph_req
);
  logic [31:0] lag_r;
  // lines move on the clock edge, unrelated to the synchroniser phase
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lag_r <= 32'h0;
      periph_req <= 32'h0;
    end else begin
      lag_r <= req_cmd;
      periph_req <= slow ? lag_r : req_cmd;
    end
  end
endmodule : vecirq_src_model

// ### verification/vecirq_top_tb.sv
/* self-checking bench for vecirq_top.
   assumes apb master here, sources from vecirq_src_model. */
`timescale 1ns/1ps
module vecirq_top_tb
  import vecirq_pkg::*;
;
  logic mclk, rstn, ce, psel, penable, pwrite, pready, pslverr, slow, stall, f_out, n_out;
  logic [31:0] paddr, pwdata, prdata, req_cmd, preq, sfb, fvec, nvec, a, b, c, m, cl, f, p;
  logic [3:0] pstrb;
  logic [32:0] exp_q[$];
  int error_cnt, tests_run, seed;

  vecirq_top u_vecirq_top (.mclk(mclk), .rstn(rstn), .ce(ce), .periph_req(preq),
    .software_force_bits(sfb), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fast_req_vec(fvec), .normal_req_vec(nvec), .fast_interrupt_out(f_out), .normal_interrupt_out(n_out));
  vecirq_src_model u_vecirq_src_model (.mclk(mclk), .rstn(rstn), .slow(slow), .req_cmd(req_cmd), .periph_req(preq));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic chk(input logic [32:0] e, input logic [32:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  // request held until pready seen high; psel left up for back-to-back
  task automatic xfer(input logic w, input logic [31:0] ad, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    if (stall) begin
      ce <= 1'b0;
      repeat (2) @(posedge mclk);
      ce <= 1'b1;
    end
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
  endtask : xfer

  task automatic rd(input logic [31:0] ad, input logic [32:0] e);
    exp_q.push_back(e);
    xfer(1'b0, ad, $random(seed));
  endtask : rd

  task automatic idle(input int n);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (n) @(posedge mclk);
  endtask : idle

  always @(posedge mclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      chk(exp_q.pop_front(), {pslverr, prdata});
    end
  end

  // bound far above the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge mclk);
    error_cnt++;
    results();
  end

  initial begin
    seed = 8;
    error_cnt = 0;
    tests_run = 0;
    {rstn, psel, penable, pwrite, slow, stall} = 6'h0;
    {paddr, pwdata, req_cmd, sfb} = 128'h0;
    ce = 1'b1;
    pstrb = 4'hF;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    rd(VECIRQ_RAW_STATUS_ADDR, 33'h0);
    rd(VECIRQ_CLASS_SEL_ADDR, 33'h0);
    rd(VECIRQ_EN_SET_ADDR, 33'h0);
    rd(VECIRQ_EN_CLR_ADDR, 33'h0);
    idle(1);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      a = $random(seed);
      b = $random(seed);
      c = $random(seed);
      cl = $random(seed);
      f = $random(seed);
      p = $random(seed);
      slow <= i[0];
      xfer(1'b1, VECIRQ_EN_CLR_ADDR, 32'hFFFFFFFF);
      xfer(1'b1, VECIRQ_EN_SET_ADDR, a);
      xfer(1'b1, VECIRQ_EN_SET_ADDR, b);
      rd(VECIRQ_EN_SET_ADDR, {1'b0, a | b});
      xfer(1'b1, VECIRQ_EN_CLR_ADDR, c);
      m = (a | b) & ~c;
      rd(VECIRQ_EN_SET_ADDR, {1'b0, m});
      rd(VECIRQ_EN_CLR_ADDR, 33'h0);
      rd(VECIRQ_EN_SET_ADDR, {1'b0, m});
      xfer(1'b1, VECIRQ_CLASS_SEL_ADDR, cl);
      stall = 1'b1;
      rd(VECIRQ_CLASS_SEL_ADDR, {1'b0, cl});
      stall = 1'b0;
      sfb <= f;
      req_cmd <= p;
      idle(12);
      rd(VECIRQ_RAW_STATUS_ADDR, {1'b0, f | p});
      xfer(1'b1, VECIRQ_RAW_STATUS_ADDR, ~(f | p));
      rd(VECIRQ_RAW_STATUS_ADDR, {1'b0, f | p});
      rd(32'hFFFFF018, {1'b1, 32'h0});
      idle(2);
      chk({1'b0, (f | p) & m & cl}, {1'b0, fvec});
      chk({1'b0, (f | p) & m & ~cl}, {1'b0, nvec});
      chk({31'h0, |((f | p) & m & cl), |((f | p) & m & ~cl)}, {31'h0, f_out, n_out});
      $display("test %0d done", i);
    end
    pstrb <= 4'h3;
    xfer(1'b1, VECIRQ_EN_SET_ADDR, 32'hFFFFFFFF);
    xfer(1'b1, VECIRQ_CLASS_SEL_ADDR, 32'h00000000);
    pstrb <= 4'hF;
    rd(VECIRQ_EN_SET_ADDR, {1'b0, m | 32'h0000FFFF});
    rd(VECIRQ_CLASS_SEL_ADDR, {1'b0, cl & 32'hFFFF0000});
    idle(1);
    $display("test strobes done");
    rstn <= 1'b0;
    idle(2);
    rstn <= 1'b1;
    idle(1);
    rd(VECIRQ_CLASS_SEL_ADDR, 33'h0);
    rd(VECIRQ_EN_SET_ADDR, 33'h0);
    idle(1);
    $display("test second reset done");
    results();
  end
endmodule : vecirq_top_tb
